// *** lm_decode_defs.svh ***
// constants for the long mode opcode validity decoder: opcodes, register map,
// reset values; included by the decoder module only
`ifndef LM_DECODE_DEFS_SVH
`define LM_DECODE_DEFS_SVH

// one-byte opcodes that fault in 64-bit mode
`define OPC_ASCII_ADJ_ADD   8'h37
`define OPC_ASCII_ADJ_SUB   8'h3f
`define OPC_ASCII_ADJ_MUL   8'hd4
`define OPC_ASCII_ADJ_DIV   8'hd5
`define OPC_DEC_ADJ_ADD     8'h27
`define OPC_DEC_ADJ_SUB     8'h2f
`define OPC_BOUND_CHECK     8'h62
`define OPC_OVF_INT         8'hce
`define OPC_FAR_CALL_ABS    8'h9a
`define OPC_FAR_JMP_ABS     8'hea
`define OPC_LOAD_DS_PTR     8'hc5
`define OPC_LOAD_ES_PTR     8'hc4
`define OPC_POP_DS          8'h1f
`define OPC_POP_ES          8'h07
`define OPC_POP_SS          8'h17
`define OPC_PUSH_CS         8'h0e
`define OPC_PUSH_DS         8'h1e
`define OPC_PUSH_ES         8'h06
`define OPC_PUSH_SS         8'h16
`define OPC_PUSH_ALL        8'h60
`define OPC_POP_ALL         8'h61
`define OPC_GRP1_DUP        8'h82
`define OPC_CARRY_ACC_SET   8'hd6

// reassigned and two-byte forms
`define OPC_PREFIX_HI_NIB   4'h4
`define OPC_SEXT_MOVE       8'h63
`define OPC_GRP_INC_DEC     8'hff
`define OPC_TWO_BYTE        8'h0f
`define OPC_FAST_ENTRY      8'h34
`define OPC_FAST_EXIT       8'h35
`define REG_FIELD_INC       3'h0
`define REG_FIELD_DEC       3'h1
`define REG_FIELD_SAVE      3'h0
`define REG_FIELD_RESTORE   3'h1

// register map, byte addresses
`define ADDR_CTRL           12'h000
`define ADDR_STATUS         12'h004
`define ADDR_FEATURE        12'h008
`define ADDR_FAULT_CNT      12'h00c

// control fields and reset values
`define CTRL_ENABLE_BIT     0
`define CTRL_CLEAR_BIT      1
`define CTRL_ENABLE_RESET   1'b1
`define FEATURE_FAST_SR_BIT 0

`endif

// *** lm_decode_pkg.sv ***
// types shared by the long mode opcode validity decoder and its bench
// assumes nothing beyond a SystemVerilog compiler
package lm_decode_pkg;

	typedef enum logic [1:0] {
		MODE_LEGACY,
		MODE_COMPAT,
		MODE_LONG64
	} cpu_mode_t;

	typedef enum logic [1:0] {
		OPSZ_16,
		OPSZ_32,
		OPSZ_64
	} op_size_t;

	typedef enum logic [3:0] {
		OP_OTHER,
		OP_FAULT,
		OP_EXT_PREFIX,
		OP_INC_REG,
		OP_DEC_REG,
		OP_INC_RM,
		OP_DEC_RM,
		OP_SEXT_MOVE,
		OP_PRIV_ADJUST,
		OP_MEDIA_SAVE,
		OP_MEDIA_RESTORE
	} op_class_t;

	// one instruction presented by fetch, with its context
	typedef struct packed {
		logic      valid;
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic      ext_prefix;
		cpu_mode_t mode;
		logic [1:0] priv_level;
		op_size_t  op_size;
		logic      fast_sr_en;
	} fetch_t;

	// decode verdict handed to the execution pipeline
	typedef struct packed {
		logic      valid;
		logic      invalid_opcode_fault;
		op_class_t op_class;
		logic [3:0] ext_bits;
		logic      src_32;
		logic      sext_to_64;
		logic      wide_format;
		logic      skip_wide_media;
		logic      save_x87_env;
	} decode_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// *** long_mode_opcode_validity_decoder.sv ***
// long mode opcode validity decoder: classifies the first instruction bytes,
// flags opcodes that are illegal in the current sub-mode and picks the
// media state save-restore format, with a small apb register block.
// assumes fetch presents a whole opcode (up to three bytes) with its mode,
// privilege, operand size and prefix flag in one cycle, all synchronous.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "lm_decode_defs.svh"

module long_mode_opcode_validity_decoder
	import lm_decode_pkg::*;
#(
	parameter int          CNT_W        = 16,
	parameter logic [7:0]  MEDIA_GRP_OP = 8'hae,
	parameter logic        FAST_SR_AVAIL = 1'b1
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	input  wire fetch_t      i_fetch,
	input  wire apb_req_t    i_apb,
	output decode_t          o_dec,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr
);

	// every piece of state in one record so freeze and reset act alike
	typedef struct packed {
		decode_t          dec;
		logic [CNT_W-1:0] fault_cnt;
		logic [7:0]       last_op;
		cpu_mode_t        last_mode;
		logic             last_fault;
		logic             enable;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} state_t;

	localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	state_t s_reg;
	state_t s_next;

	// decode scratch, filled in the combinational process
	logic      is_64;
	logic      is_long;
	logic      bad_in_64;
	logic      bad_in_long;
	logic      take;
	logic      fault;
	logic [2:0] reg1;
	logic [2:0] reg2;
	decode_t   d;

	// apb scratch
	logic      apb_access;
	logic      apb_wr;
	logic      apb_rd;
	logic      hit;
	logic [31:0] rdata;
	logic      clear_cnt;

	// mode and operand-form fields used by several checks
	assign is_64   = (i_fetch.mode == MODE_LONG64);
	assign is_long = is_64 | (i_fetch.mode == MODE_COMPAT);
	assign reg1    = i_fetch.byte1[5:3];
	assign reg2    = i_fetch.byte2[5:3];
	assign take    = i_fetch.valid & s_reg.enable;

	// table of one-byte opcodes that are illegal only in 64-bit mode
	always_comb begin
		case (i_fetch.byte0)
			`OPC_ASCII_ADJ_ADD,
			`OPC_ASCII_ADJ_SUB,
			`OPC_ASCII_ADJ_MUL,
			`OPC_ASCII_ADJ_DIV: bad_in_64 = 1'b1;
			`OPC_DEC_ADJ_ADD,
			`OPC_DEC_ADJ_SUB: bad_in_64 = 1'b1;
			`OPC_BOUND_CHECK,
			`OPC_OVF_INT: bad_in_64 = 1'b1;
			`OPC_FAR_CALL_ABS,
			`OPC_FAR_JMP_ABS: bad_in_64 = 1'b1;
			`OPC_LOAD_DS_PTR,
			`OPC_LOAD_ES_PTR: bad_in_64 = 1'b1;
			`OPC_POP_DS,
			`OPC_POP_ES,
			`OPC_POP_SS: bad_in_64 = 1'b1;
			`OPC_PUSH_CS,
			`OPC_PUSH_DS,
			`OPC_PUSH_ES,
			`OPC_PUSH_SS: bad_in_64 = 1'b1;
			`OPC_PUSH_ALL,
			`OPC_POP_ALL: bad_in_64 = 1'b1;
			`OPC_GRP1_DUP,
			`OPC_CARRY_ACC_SET: bad_in_64 = 1'b1;
			default: bad_in_64 = 1'b0;
		endcase
	end

	// fast system entry and exit are gone in both long sub-modes
	assign bad_in_long = (i_fetch.byte0 == `OPC_TWO_BYTE) &&
	                     ((i_fetch.byte1 == `OPC_FAST_ENTRY) ||
	                      (i_fetch.byte1 == `OPC_FAST_EXIT));

	// the fault wins over any other meaning of the bytes
	assign fault = take & ((is_64 & bad_in_64) | (is_long & bad_in_long));

	// classification, all in the cycle the bytes are presented
	always_comb begin
		d = '0;
		d.valid = take;
		d.invalid_opcode_fault = fault;
		d.save_x87_env = 1'b1;
		d.op_class = OP_OTHER;
		if (!take) begin
			d = '0;
		end else if (fault) begin
			// no execution class is handed on with a fault
			d.op_class = OP_FAULT;
		end else if (i_fetch.byte0[7:4] == `OPC_PREFIX_HI_NIB) begin
			if (is_64) begin
				d.op_class = OP_EXT_PREFIX;
				d.ext_bits = i_fetch.byte0[3:0];
			end else if (i_fetch.byte0[3]) begin
				d.op_class = OP_DEC_REG;
			end else begin
				d.op_class = OP_INC_REG;
			end
		end else if (i_fetch.byte0 == `OPC_GRP_INC_DEC) begin
			// register and memory forms stay legal in every mode
			if (reg1 == `REG_FIELD_INC) begin
				d.op_class = OP_INC_RM;
			end else if (reg1 == `REG_FIELD_DEC) begin
				d.op_class = OP_DEC_RM;
			end
		end else if (i_fetch.byte0 == `OPC_SEXT_MOVE) begin
			if (is_64) begin
				d.op_class = OP_SEXT_MOVE;
				d.src_32 = 1'b1;
				d.sext_to_64 = i_fetch.ext_prefix;
			end else begin
				d.op_class = OP_PRIV_ADJUST;
			end
		end else if ((i_fetch.byte0 == `OPC_TWO_BYTE) &&
		             (i_fetch.byte1 == MEDIA_GRP_OP) &&
		             ((reg2 == `REG_FIELD_SAVE) || (reg2 == `REG_FIELD_RESTORE))) begin
			d.op_class = (reg2 == `REG_FIELD_SAVE) ? OP_MEDIA_SAVE : OP_MEDIA_RESTORE;
			// only an explicit 64-bit size picks the expanded image
			d.wide_format = (i_fetch.op_size == OPSZ_64);
			// fast skip needs all three conditions, else full set moves
			d.skip_wide_media = i_fetch.fast_sr_en & is_64 &
			                    (i_fetch.priv_level == 2'h0);
			d.save_x87_env = 1'b1;
		end
	end

	// apb phase decode; pready answers one cycle into the access phase
	assign apb_access = i_apb.psel & i_apb.penable & ~s_reg.pready;
	assign apb_wr     = apb_access & i_apb.pwrite;
	assign apb_rd     = apb_access & ~i_apb.pwrite;

	// register read mux; unmapped addresses read zero and raise pslverr
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (i_apb.paddr)
			`ADDR_CTRL: begin
				rdata[`CTRL_ENABLE_BIT] = s_reg.enable;
			end
			`ADDR_STATUS: begin
				rdata[7:0] = s_reg.last_op;
				rdata[9:8] = s_reg.last_mode;
				rdata[16] = s_reg.last_fault;
			end
			`ADDR_FEATURE: begin
				// software tests this before setting the enable bit
				rdata[`FEATURE_FAST_SR_BIT] = FAST_SR_AVAIL;
			end
			`ADDR_FAULT_CNT: begin
				rdata[CNT_W-1:0] = s_reg.fault_cnt;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// clear bit is a write-one strobe and never stored
	assign clear_cnt = apb_wr && (i_apb.paddr == `ADDR_CTRL) &&
	                   i_apb.pwdata[`CTRL_CLEAR_BIT];

	// next state
	always_comb begin
		s_next = s_reg;
		s_next.dec = d;
		// status follows the last opcode actually decoded
		if (take) begin
			s_next.last_op = i_fetch.byte0;
			s_next.last_mode = i_fetch.mode;
			s_next.last_fault = fault;
		end
		// a fault landing with a clear still counts, and the count saturates
		if (clear_cnt) begin
			s_next.fault_cnt = fault ? CNT_ONE : '0;
		end else if (fault && (s_reg.fault_cnt != CNT_MAX)) begin
			s_next.fault_cnt = s_reg.fault_cnt + CNT_ONE;
		end
		if (apb_wr && (i_apb.paddr == `ADDR_CTRL)) begin
			s_next.enable = i_apb.pwdata[`CTRL_ENABLE_BIT];
		end
		// answer lasts one cycle; read data holds until the next read
		s_next.pready = apb_access;
		s_next.pslverr = apb_access & ~hit;
		if (apb_rd) begin
			s_next.prdata = rdata;
		end
	end

	// registered state; clock enable low freezes everything
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			s_reg <= '0;
			s_reg.enable <= `CTRL_ENABLE_RESET;
			s_reg.last_mode <= MODE_LEGACY;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state record
	assign o_dec     = s_reg.dec;
	assign o_prdata  = s_reg.prdata;
	assign o_pready  = s_reg.pready;
	assign o_pslverr = s_reg.pslverr;

endmodule

// *** lm_decode_asserts.sv ***
// concurrent checks on the decode verdicts of the opcode validity decoder
// assumes a verdict lands one cycle after a taken edge; a frozen edge takes no obligation
`timescale 1ns/10ps
module lm_decode_asserts
	import lm_decode_pkg::*;
#(
	parameter logic [7:0] MEDIA_GRP_OP = 8'hae
) (
	input wire logic    i_core_clk,
	input wire logic    i_reset,
	input wire logic    i_ce,
	input wire fetch_t  i_fetch,
	input wire decode_t o_dec
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	logic take;
	logic l64;
	logic media;
	logic fast;
	// verdicts may be zero while decoding is switched off, so each check except a_fast_inert allows !valid
	assign take  = i_ce && i_fetch.valid;
	assign l64   = i_fetch.mode == MODE_LONG64;
	// only the save (/0) and restore (/1) forms of the group carry a format
	assign media = i_fetch.byte0 == 8'h0f && i_fetch.byte1 == MEDIA_GRP_OP
		&& i_fetch.byte2[5:4] == 2'h0;
	assign fast  = i_fetch.fast_sr_en && l64 && i_fetch.priv_level == 2'h0;
	a_illegal_64_fault: assert property (
		take && l64 && i_fetch.byte0 inside {8'h37, 8'h3f, 8'hd4, 8'hd5, 8'h27, 8'h2f, 8'h62,
		8'hce, 8'h9a, 8'hea, 8'hc5, 8'hc4, 8'h1f, 8'h07, 8'h17, 8'h0e, 8'h1e, 8'h06, 8'h16,
		8'h60, 8'h61, 8'h82, 8'hd6} |=> !o_dec.valid || o_dec.invalid_opcode_fault)
		else $error("opcode illegal in 64-bit mode was not faulted");
	a_long_entry_fault: assert property (
		take && i_fetch.mode != MODE_LEGACY && i_fetch.byte0 == 8'h0f
		&& i_fetch.byte1 inside {8'h34, 8'h35} |=> !o_dec.valid || o_dec.invalid_opcode_fault)
		else $error("fast system entry or exit not faulted in long mode");
	a_prefix_class: assert property (
		take && l64 && i_fetch.byte0[7:4] == 4'h4 |=> !o_dec.valid
		|| (o_dec.op_class == OP_EXT_PREFIX && o_dec.ext_bits == $past(i_fetch.byte0[3:0])))
		else $error("byte 40 to 4f not a prefix in 64-bit mode");
	a_short_inc_dec: assert property (
		take && !l64 && i_fetch.byte0[7:4] == 4'h4 |=> !o_dec.valid
		|| o_dec.op_class == ($past(i_fetch.byte0[3]) ? OP_DEC_REG : OP_INC_REG))
		else $error("one-byte increment or decrement misclassified");
	a_group_inc_dec: assert property (
		take && l64 && i_fetch.byte0 == 8'hff && i_fetch.byte1[5:4] == 2'h0 |=> !o_dec.valid
		|| o_dec.op_class == ($past(i_fetch.byte1[3]) ? OP_DEC_RM : OP_INC_RM))
		else $error("two-byte increment or decrement misclassified");
	a_sign_ext_move: assert property (
		take && l64 && i_fetch.byte0 == 8'h63 |=> !o_dec.valid || (o_dec.op_class == OP_SEXT_MOVE
		&& o_dec.src_32 && o_dec.sext_to_64 == $past(i_fetch.ext_prefix)))
		else $error("sign-extend move decoded wrongly");
	a_media_format: assert property (
		take && media |=> !o_dec.valid || o_dec.wide_format == ($past(i_fetch.op_size) == OPSZ_64))
		else $error("save image format does not follow operand size");
	a_media_skip: assert property (
		take && media && fast |=> !o_dec.valid || o_dec.skip_wide_media)
		else $error("wide registers not skipped with fast save enabled");
	a_fast_inert: assert property (
		take && !fast |=> !o_dec.skip_wide_media)
		else $error("wide registers skipped outside 64-bit level zero");
	a_env_saved: assert property (
		o_dec.valid |-> o_dec.save_x87_env)
		else $error("x87 environment save dropped");
	c_fault: cover property (o_dec.valid && o_dec.invalid_opcode_fault);
	c_skip: cover property (o_dec.skip_wide_media);
	c_sext: cover property (o_dec.op_class == OP_SEXT_MOVE && o_dec.sext_to_64);
endmodule

bind long_mode_opcode_validity_decoder lm_decode_asserts #(.MEDIA_GRP_OP(MEDIA_GRP_OP)) u_chk (
	.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce), .i_fetch(i_fetch), .o_dec(o_dec));

// *** lm_fetch_model.sv ***
// fetch unit stand-in: presents one opcode with its context for one cycle
// assumes the bench raises i_go for a single clock per request
`timescale 1ns/10ps
module lm_fetch_model
	import lm_decode_pkg::*;
(
	input  wire logic   i_core_clk,
	input  wire logic   i_go,
	input  wire fetch_t i_req,
	output fetch_t      o_fetch
);
	initial o_fetch = '0;
	// idle byte0 keeps toggling so a decoder that ignores valid sees garbage
	always @(posedge i_core_clk) begin
		if (i_go) begin
			o_fetch <= i_req;
		end else begin
			o_fetch.valid <= 1'b0;
			o_fetch.byte0 <= ~o_fetch.byte0;
		end
	end
endmodule

// *** long_mode_opcode_validity_decoder_tb.sv ***
// bench for the opcode validity decoder: opcode table, illegal opcode sweep,
// register reads, refusal while disabled or frozen and a reset in mid-run
// assumes a verdict one cycle after fetch and pready one cycle after access
`timescale 1ns/10ps
module long_mode_opcode_validity_decoder_tb;
	import lm_decode_pkg::*;
	typedef struct {
		logic [23:0] op;
		logic [1:0]  m, s, c;
		logic [4:0]  fl; // fast enable, prefix, fault, wide, skip
		op_class_t   ec;
	} row_t;
	logic        i_core_clk   = 1'b0;
	logic        i_reset      = 1'b1;
	logic        go           = 1'b0;
	logic        ce           = 1'b1;
	fetch_t      req          = '0;
	apb_req_t    apb          = '0;
	fetch_t      fetch;
	decode_t     o_dec;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic [31:0] rd;
	logic        err;
	row_t        r;
	int          err_total    = 0;
	int          total_checks = 0;
	int          cycles       = 0;
	logic [7:0]  bad[23] = '{8'h37, 8'h3f, 8'hd4, 8'hd5, 8'h27, 8'h2f, 8'h62, 8'hce, 8'h9a,
		8'hea, 8'hc5, 8'hc4, 8'h1f, 8'h07, 8'h17, 8'h0e, 8'h1e, 8'h06, 8'h16, 8'h60, 8'h61,
		8'h82, 8'hd6};
	row_t        rows[14] = '{
		'{24'h400000, 2'h2, 2'h1, 2'h0, 5'b00000, OP_EXT_PREFIX},
		'{24'h4b0000, 2'h0, 2'h1, 2'h0, 5'b00000, OP_DEC_REG},
		'{24'h420000, 2'h1, 2'h1, 2'h0, 5'b00000, OP_INC_REG},
		'{24'hffc000, 2'h2, 2'h1, 2'h0, 5'b00000, OP_INC_RM},
		'{24'hffc800, 2'h2, 2'h1, 2'h0, 5'b00000, OP_DEC_RM},
		'{24'h630000, 2'h2, 2'h1, 2'h0, 5'b01000, OP_SEXT_MOVE},
		'{24'h630000, 2'h1, 2'h1, 2'h0, 5'b00000, OP_PRIV_ADJUST},
		'{24'h0f3400, 2'h1, 2'h1, 2'h0, 5'b00100, OP_FAULT},
		'{24'h0f3500, 2'h2, 2'h1, 2'h0, 5'b00100, OP_FAULT},
		'{24'h0fae00, 2'h2, 2'h1, 2'h0, 5'b00000, OP_MEDIA_SAVE},
		'{24'h0fae08, 2'h2, 2'h2, 2'h0, 5'b00010, OP_MEDIA_RESTORE},
		'{24'h0fae00, 2'h2, 2'h1, 2'h0, 5'b10001, OP_MEDIA_SAVE},
		'{24'h0fae00, 2'h2, 2'h1, 2'h3, 5'b10000, OP_MEDIA_SAVE},
		'{24'h0fae08, 2'h1, 2'h2, 2'h0, 5'b10010, OP_MEDIA_RESTORE}};

	lm_fetch_model u_fetch (.i_core_clk(i_core_clk), .i_go(go), .i_req(req), .o_fetch(fetch));
	// clock enable comes from the bench so the freeze path is exercised
	long_mode_opcode_validity_decoder u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_ce(ce), .i_fetch(fetch), .i_apb(apb), .o_dec(o_dec), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr));

	always #20 i_core_clk = ~i_core_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	// one request through the fetch model, verdict settled on return
	task automatic dec(input fetch_t f);
		@(posedge i_core_clk);
		req <= f;
		go  <= 1'b1;
		@(posedge i_core_clk);
		go <= 1'b0;
		@(posedge i_core_clk);
		#1;
	endtask

	// apb transfer; holds the request until pready is sampled high, only the timeout ends it
	task automatic apb_io(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge i_core_clk);
		apb <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge i_core_clk);
		apb.penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (o_pready !== 1'b1);
		rd  = o_prdata;
		err = o_pslverr;
		apb <= '0;
	endtask

	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// a hang counts as a failure
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		foreach (rows[i]) begin
			r = rows[i];
			dec('{1'b1, r.op[23:16], r.op[15:8], r.op[7:0], r.fl[3], cpu_mode_t'(r.m), r.c,
				op_size_t'(r.s), r.fl[4]});
			chk({o_dec.valid, o_dec.invalid_opcode_fault, o_dec.op_class, o_dec.wide_format,
				o_dec.skip_wide_media, o_dec.save_x87_env}, {1'b1, r.fl[2], r.ec, r.fl[1:0], 1'b1});
		end
		foreach (bad[i]) begin
			dec('{1'b1, bad[i], 8'h00, 8'h00, 1'b0, MODE_LONG64, 2'h0, OPSZ_32, 1'b0});
			chk(o_dec.invalid_opcode_fault, 32'h1);
			dec('{1'b1, bad[i], 8'h00, 8'h00, 1'b0, MODE_COMPAT, 2'h0, OPSZ_32, 1'b0});
			chk(o_dec.invalid_opcode_fault, 32'h0);
		end
		// clock enable low: a faulting opcode neither shows nor counts
		@(posedge i_core_clk);
		ce <= 1'b0;
		dec('{1'b1, 8'h37, 8'h00, 8'h00, 1'b0, MODE_LONG64, 2'h0, OPSZ_32, 1'b0});
		chk(o_dec, 32'h0);
		@(posedge i_core_clk);
		ce <= 1'b1;
		apb_io(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h1);
		apb_io(1'b0, 12'h010, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		// two faulting rows plus the 64-bit sweep, nothing from the frozen cycle
		apb_io(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h19);
		// decoding switched off: the fault must not reach the pipeline
		apb_io(1'b1, 12'h000, 32'h0);
		dec('{1'b1, 8'h37, 8'h00, 8'h00, 1'b0, MODE_LONG64, 2'h0, OPSZ_32, 1'b0});
		chk(o_dec, 32'h0);
		// clear strobe while still disabled, so reset must bring the enable back
		apb_io(1'b1, 12'h000, 32'h2);
		apb_io(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		apb_io(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h1d6);
		@(posedge i_core_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		#1;
		chk(o_dec, 32'h0);
		chk(o_prdata, 32'h0);
		apb_io(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		report_and_stop();
	end
endmodule
